// >>> testbench/ppci_ctrl_model.sv
// motion controller model sending command pulse trains
`timescale 1ns/1ps
`default_nettype none
module ppci_ctrl_model (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic        line_hi_i,
    input  wire logic [15:0] hi_cyc_i,
    input  wire logic [15:0] lo_cyc_i,
    input  wire logic [7:0]  count_i,
    output logic             pulse_low_o,
    output logic             pulse_high_o,
    output logic             busy_o
);
    // ****************************************
    // pulse train generator
    // ****************************************
    // both lines are push-pull and rest low between trains
    initial begin
        pulse_low_o  = 1'b0;
        pulse_high_o = 1'b0;
        busy_o       = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                repeat (count_i) begin
                    if (line_hi_i) begin
                        pulse_high_o <= 1'b1;
                    end else begin
                        pulse_low_o <= 1'b1;
                    end
                    repeat (hi_cyc_i) @(posedge clk_i);
                    pulse_low_o  <= 1'b0;
                    pulse_high_o <= 1'b0;
                    repeat (lo_cyc_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule // ppci_ctrl_model
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench of the position pulse command input
`timescale 1ns/1ps
`default_nettype none
`include "ppci_defs.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    n_fail++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic [3:0]  wb_sel = 4'hF;
    logic        wb_we = 1'b0;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_ack;
    logic        pulse_low;
    logic        pulse_high;
    logic        cmd_dir = 1'b0;
    logic        int_step = 1'b0;
    logic        gain_sw = 1'b0;
    logic        int_dir = 1'b0;
    logic        cmd_step;
    int          n_step = 0;
    logic        mult_act;
    logic [31:0] position;
    logic        go = 1'b0;
    logic        line_hi = 1'b0;
    logic [15:0] hi_cyc = 16'h0;
    logic [15:0] lo_cyc = 16'h0;
    logic [7:0]  cnt = 8'h0;
    logic        busy;
    logic [3:0]  sel_v = 4'hF;
    logic [31:0] rd;
    logic [31:0] exp_pos = 32'h0;
    int          n_fail = 0;
    int          samples_checked = 0;
    logic [12:0] pre_w [8] = '{13'h0008, 13'h000C, 13'h0010, 13'h0028,
                               13'h0050, 13'h00A0, 13'h0140, 13'h0280};

    always #4 clk_i = ~clk_i;

    // counts the one-cycle step strobes seen on the output
    always @(posedge clk_i) begin
        if (cmd_step === 1'b1) begin
            n_step <= n_step + 1;
        end
    end

    ppci_top #(.RATE_WIN_CYC(64)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat_w), .wb_sel_i(wb_sel), .wb_we_i(wb_we),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_r),
        .wb_ack_o(wb_ack), .pulse_low_i(pulse_low),
        .pulse_high_i(pulse_high), .cmd_dir_i(cmd_dir),
        .int_step_i(int_step), .int_dir_i(int_dir),
        .gain_switch_i(gain_sw), .multiplier_active_out_o(mult_act),
        .position_o(position), .cmd_step_o(cmd_step));

    ppci_ctrl_model ctrl (
        .clk_i(clk_i), .go_i(go), .line_hi_i(line_hi),
        .hi_cyc_i(hi_cyc), .lo_cyc_i(lo_cyc), .count_i(cnt),
        .pulse_low_o(pulse_low), .pulse_high_o(pulse_high),
        .busy_o(busy));

    // ****************************************
    // bus, pulse and closing tasks
    // ****************************************
    task automatic wb_rw(input logic we, input logic [7:0] a,
                         input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_w <= d;
        wb_sel   <= sel_v;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (n >= 20) n_fail++;
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb_rw(1'b1, a, d);
    endtask

    task automatic rdv(input logic [7:0] a);
        wb_rw(1'b0, a, 32'h0);
    endtask

    task automatic send(input logic l, input logic [15:0] h,
                        input logic [15:0] lo, input logic [7:0] n);
        int k;
        k = 0;
        @(posedge clk_i);
        line_hi <= l;
        hi_cyc  <= h;
        lo_cyc  <= lo;
        cnt     <= n;
        go      <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        do begin
            @(posedge clk_i);
            k++;
        end while (busy === 1'b1 && k < 60000);
        repeat (12) @(posedge clk_i);
    endtask

    task automatic steps(input int n);
        repeat (n) begin
            @(posedge clk_i);
            int_step <= 1'b1;
            @(posedge clk_i);
            int_step <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
    endtask

    function automatic logic act_f(input logic [1:0] ms, input logic g);
        return ms == 2'h1 || (ms == 2'h2 && g);
    endfunction

    function automatic logic [31:0] delta_f(input logic [1:0] ms,
        input logic g, input logic [6:0] f, input logic [7:0] n,
        input logic dir);
        logic [31:0] v;
        v = act_f(ms, g) ? f * n : 32'(n);
        return dir ? -v : v;
    endfunction

    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #700000;
        n_fail++;
        test_done();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [1:0] ms;
        logic [6:0] f;
        logic       g;
        logic       dir;
        logic [7:0] n;
        int         k0;
        void'($urandom(15));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rdv(`PPC_OFF_CTRL);
        `CHK("ctrl reset", 32'h00000020, rd)
        rdv(`PPC_OFF_CWIDTH);
        `CHK("cwidth reset", 32'h00000190, rd)
        rdv(`PPC_OFF_FACTOR);
        `CHK("factor reset", 32'h00000001, rd)
        `CHK("active reset", 1'b0, mult_act)
        rdv(8'h20);
        `CHK("unmapped", 32'h00000000, rd)
        wr(`PPC_OFF_CWIDTH, 32'h00001FFF);
        rdv(`PPC_OFF_CWIDTH);
        `CHK("cwidth max", 32'h00001388, rd)
        wr(`PPC_OFF_FACTOR, 32'h00000000);
        rdv(`PPC_OFF_FACTOR);
        `CHK("factor min", 32'h00000001, rd)
        wr(`PPC_OFF_FACTOR, 32'h000000C8);
        sel_v = 4'h0;
        wr(`PPC_OFF_FACTOR, 32'h00000005);
        sel_v = 4'hF;
        rdv(`PPC_OFF_FACTOR);
        `CHK("factor max", 32'h00000064, rd)
        $display("test registers done");
        for (int s = 0; s < 4; s++) begin
            wr(`PPC_OFF_CTRL, 32'(s));
            send(1'b0, 16'd40, 16'd40, 8'd2);
            send(1'b1, 16'd40, 16'd40, 8'd2);
            steps(2);
            exp_pos += (s == 2) ? 32'h0 : 32'h2;
            `CHK("source pos", exp_pos, position)
        end
        $display("test source done");
        for (int i = 0; i < 8; i++) begin
            wr(`PPC_OFF_CTRL, 32'(i << 4));
            send(1'b0, 16'(pre_w[i]), 16'(pre_w[i] * 2 + 4), 8'd1);
            send(1'b0, 16'(pre_w[i] * 2 + 4), 16'(pre_w[i] * 2 + 4), 8'd1);
            exp_pos += 32'h1;
            `CHK("preset pos", exp_pos, position)
        end
        wr(`PPC_OFF_CTRL, 32'h00000010);
        send(1'b0, 16'd16, 16'd40, 8'd1);
        send(1'b0, 16'd24, 16'd24, 8'd1);
        exp_pos += 32'h1;
        `CHK("150ns pos", exp_pos, position)
        wr(`PPC_OFF_CWIDTH, 32'h00000014);
        wr(`PPC_OFF_CTRL, 32'h00000080);
        send(1'b0, 16'd20, 16'd44, 8'd1);
        send(1'b0, 16'd44, 16'd44, 8'd1);
        wr(`PPC_OFF_CWIDTH, 32'h00000000);
        send(1'b0, 16'd4, 16'd4, 8'd3);
        exp_pos += 32'h4;
        `CHK("custom pos", exp_pos, position)
        $display("test filter done");
        for (int i = 0; i < 9; i++) begin
            ms = 2'(i % 3);
            f = (i < 3) ? 7'h64 : 7'(1 + $urandom % 100);
            g = 1'($urandom % 2);
            n = 8'(1 + $urandom % 3);
            dir = 1'($urandom % 2);
            wr(`PPC_OFF_FACTOR, 32'(f));
            wr(`PPC_OFF_CTRL, 32'(ms) << 8);
            gain_sw <= g;
            cmd_dir <= dir;
            repeat (8) @(posedge clk_i);
            `CHK("active out", act_f(ms, g), mult_act)
            rdv(`PPC_OFF_STATUS);
            `CHK("status", {30'h0, g, act_f(ms, g)}, rd)
            send(1'b0, 16'd40, 16'd40, n);
            exp_pos += delta_f(ms, g, f, n, dir);
            `CHK("mult pos", exp_pos, position)
        end
        $display("test multiplier done");
        // steady internal stream: one step every 2 cycles, downwards
        wr(`PPC_OFF_CTRL, 32'h00000003);
        int_dir <= 1'b1;
        k0 = n_step;
        fork
            steps(100);
            begin
                repeat (150) @(posedge clk_i);
                rdv(`PPC_OFF_RATE);
            end
        join
        exp_pos -= 32'd100;
        `CHK("rate", 32'd32, rd)
        `CHK("step pos", exp_pos, position)
        `CHK("step out", 100, n_step - k0)
        rdv(`PPC_OFF_POS);
        `CHK("pos read", exp_pos, rd)
        wr(`PPC_OFF_CTRL, 32'h000003F1);
        rdv(`PPC_OFF_CTRL);
        `CHK("ctrl resv", 32'h00000001, rd)
        wr(`PPC_OFF_POS, 32'h00ABCDEF);
        `CHK("pos write", 32'h00ABCDEF, position)
        $display("test internal done");
        test_done();
    end
endmodule // tb_top
`default_nettype wire

// >>> verilog/ppci_defs.svh
// constants of the position pulse command input block
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

`define PPC_ADR_W        8
`define PPC_OFF_CTRL     8'h00
`define PPC_OFF_CWIDTH   8'h04
`define PPC_OFF_FACTOR   8'h08
`define PPC_OFF_STATUS   8'h0C
`define PPC_OFF_POS      8'h10
`define PPC_OFF_RATE     8'h14

`define PPC_CTRL_SRC_LSB   0
`define PPC_CTRL_FILT_LSB  4
`define PPC_CTRL_MSEL_LSB  8

`define PPC_RST_SRC      2'h0
`define PPC_RST_FILT     4'h2
`define PPC_RST_MSEL     2'h0
`define PPC_RST_CWIDTH   13'h0190
`define PPC_RST_FACTOR   7'h01
`define PPC_CWIDTH_MAX   13'h1388
`define PPC_FACTOR_MIN   7'h01
`define PPC_FACTOR_MAX   7'h64
`define PPC_FILT_CUSTOM  4'h8

`define PPC_CLK_PS       8000
`define PPC_TICK_PS      12500
`define PPC_RATE_WIN_NS  1000000
`define PPC_RATE_WIN_CYC (`PPC_RATE_WIN_NS * 1000 / `PPC_CLK_PS)

`endif

// >>> verilog/ppci_filter.sv
// width filter for one command pulse line
`timescale 1ns/1ps
`default_nettype none
module ppci_filter (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        raw_i,
    input  wire logic        tick_i,
    input  wire logic [12:0] width_i,
    output logic             clean_o,
    output logic             rise_o
);
    logic [13:0] cnt_q;

    // phase length counted in base ticks while input differs from output
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= 14'h0000;
        end else if (raw_i == clean_o || cnt_q > {1'b0, width_i}) begin
            cnt_q <= 14'h0000;
        end else if (tick_i) begin
            cnt_q <= cnt_q + 14'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clean_o <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            rise_o <= 1'b0;
            if (raw_i != clean_o && cnt_q > {1'b0, width_i}) begin
                clean_o <= raw_i;
                rise_o  <= raw_i;
            end
        end
    end

    filt_accept_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(clean_o) |-> $past(cnt_q) > {1'b0, $past(width_i)})
        else $error("filter accepted a phase not longer than width");

    filt_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (raw_i == clean_o) |=> cnt_q == 14'h0000)
        else $error("filter count not cleared on matching level");

endmodule // ppci_filter
`default_nettype wire

// >>> verilog/ppci_pkg.sv
// types of the position pulse command input block
package ppci_pkg;

    typedef enum logic [1:0] {
        PPCI_SRC_LOW  = 2'h0,
        PPCI_SRC_HIGH = 2'h1,
        PPCI_SRC_RESV = 2'h2,
        PPCI_SRC_INT  = 2'h3
    } ppci_src_t;

    typedef enum logic [1:0] {
        PPCI_MSEL_OFF = 2'h0,
        PPCI_MSEL_ON  = 2'h1,
        PPCI_MSEL_SW  = 2'h2,
        PPCI_MSEL_RSV = 2'h3
    } ppci_msel_t;

    typedef struct packed {
        ppci_src_t   src;
        logic [3:0]  filt;
        ppci_msel_t  msel;
        logic [12:0] cwidth;
        logic [6:0]  factor;
    } ppci_cfg_t;

endpackage

// >>> verilog/ppci_top.sv
// position pulse command input with wishbone register access
//
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ppci_defs.svh"
module ppci_top
    import ppci_pkg::*;
#(
    parameter int          RATE_WIN_CYC = `PPC_RATE_WIN_CYC,
    parameter logic [12:0] PRESET_W0    = 13'h0008,
    parameter logic [12:0] PRESET_W1    = 13'h000C,
    parameter logic [12:0] PRESET_W2    = 13'h0010,
    parameter logic [12:0] PRESET_W3    = 13'h0028,
    parameter logic [12:0] PRESET_W4    = 13'h0050,
    parameter logic [12:0] PRESET_W5    = 13'h00A0,
    parameter logic [12:0] PRESET_W6    = 13'h0140,
    parameter logic [12:0] PRESET_W7    = 13'h0280
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        pulse_low_i,
    input  wire logic        pulse_high_i,
    input  wire logic        cmd_dir_i,
    input  wire logic        int_step_i,
    input  wire logic        int_dir_i,
    input  wire logic        gain_switch_i,
    output logic             multiplier_active_out_o,
    output logic [31:0]      position_o,
    output logic             cmd_step_o
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       plow_s;
    logic       phigh_s;
    logic       dir_s;
    logic       gain_s;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= 4'h0;
            sync_q <= 4'h0;
        end else begin
            meta_q <= {gain_switch_i, cmd_dir_i, pulse_high_i, pulse_low_i};
            sync_q <= meta_q;
        end
    end

    assign plow_s  = sync_q[0];
    assign phigh_s = sync_q[1];
    assign dir_s   = sync_q[2];
    assign gain_s  = sync_q[3];

    // ************************************************************
    // configuration registers
    // ************************************************************
    ppci_cfg_t   cfg_q;
    logic        wb_req;
    logic        wb_wr;
    logic [31:0] ctrl_rd;

    assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr   = wb_req && wb_we_i;
    assign ctrl_rd = {22'h0, cfg_q.msel, cfg_q.filt, 2'h0, cfg_q.src};

    function automatic logic [31:0] merge(input logic [31:0] old_v);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
                r[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [6:0] clamp_factor(input logic [31:0] v);
        if (v[31:7] != 25'h0 || v[6:0] > `PPC_FACTOR_MAX) begin
            return `PPC_FACTOR_MAX;
        end else if (v[6:0] < `PPC_FACTOR_MIN) begin
            return `PPC_FACTOR_MIN;
        end
        return v[6:0];
    endfunction

    always_ff @(posedge clk_i) begin
        logic [31:0] m;
        m = 32'h0;
        if (rst_i) begin
            cfg_q.src    <= ppci_src_t'(`PPC_RST_SRC);
            cfg_q.filt   <= `PPC_RST_FILT;
            cfg_q.msel   <= ppci_msel_t'(`PPC_RST_MSEL);
            cfg_q.cwidth <= `PPC_RST_CWIDTH;
            cfg_q.factor <= `PPC_RST_FACTOR;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                `PPC_OFF_CTRL: begin
                    m = merge(ctrl_rd);
                    cfg_q.src  <= ppci_src_t'(m[`PPC_CTRL_SRC_LSB +: 2]);
                    if (m[`PPC_CTRL_FILT_LSB +: 4] <= `PPC_FILT_CUSTOM) begin
                        cfg_q.filt <= m[`PPC_CTRL_FILT_LSB +: 4];
                    end
                    if (m[`PPC_CTRL_MSEL_LSB +: 2] != 2'h3) begin
                        cfg_q.msel <= ppci_msel_t'(m[`PPC_CTRL_MSEL_LSB +: 2]);
                    end
                end
                `PPC_OFF_CWIDTH: begin
                    m = merge({19'h0, cfg_q.cwidth});
                    if (m[31:13] != 19'h0 || m[12:0] > `PPC_CWIDTH_MAX) begin
                        cfg_q.cwidth <= `PPC_CWIDTH_MAX;
                    end else begin
                        cfg_q.cwidth <= m[12:0];
                    end
                end
                `PPC_OFF_FACTOR: begin
                    m = merge({25'h0, cfg_q.factor});
                    cfg_q.factor <= clamp_factor(m);
                end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // filter width and 12.5 ns base tick
    // ************************************************************
    logic [12:0] width_q;
    logic [14:0] tacc_q;
    logic        tick_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            width_q <= PRESET_W2;
        end else begin
            unique case (cfg_q.filt)
                4'h0:    width_q <= PRESET_W0;
                4'h1:    width_q <= PRESET_W1;
                4'h2:    width_q <= PRESET_W2;
                4'h3:    width_q <= PRESET_W3;
                4'h4:    width_q <= PRESET_W4;
                4'h5:    width_q <= PRESET_W5;
                4'h6:    width_q <= PRESET_W6;
                4'h7:    width_q <= PRESET_W7;
                default: width_q <= cfg_q.cwidth;
            endcase
        end
    end

    // fractional accumulator: one tick per 12.5 ns on average
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tacc_q <= 15'h0000;
            tick_q <= 1'b0;
        end else if (tacc_q + 15'(`PPC_CLK_PS) >= 15'(`PPC_TICK_PS)) begin
            tacc_q <= tacc_q + 15'(`PPC_CLK_PS) - 15'(`PPC_TICK_PS);
            tick_q <= 1'b1;
        end else begin
            tacc_q <= tacc_q + 15'(`PPC_CLK_PS);
            tick_q <= 1'b0;
        end
    end

    // ************************************************************
    // source select and filtering
    // ************************************************************
    logic ext_raw;
    logic ext_rise;
    logic step;
    logic step_dir;

    assign ext_raw = (cfg_q.src == PPCI_SRC_HIGH) ? phigh_s : plow_s;

    ppci_filter u_filter (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .raw_i   (ext_raw),
        .tick_i  (tick_q),
        .width_i (width_q),
        .clean_o (),
        .rise_o  (ext_rise)
    );

    always_comb begin
        step     = 1'b0;
        step_dir = dir_s;
        unique case (cfg_q.src)
            PPCI_SRC_LOW, PPCI_SRC_HIGH: step = ext_rise;
            PPCI_SRC_INT: begin
                step     = int_step_i;
                step_dir = int_dir_i;
            end
            PPCI_SRC_RESV: step = 1'b0;
        endcase
    end

    // ************************************************************
    // multiplier and position count
    // ************************************************************
    logic       mact;
    logic [6:0] delta;
    logic [31:0] rate_acc_q;
    logic [31:0] rate_q;
    logic [31:0] win_q;

    always_comb begin
        unique case (cfg_q.msel)
            PPCI_MSEL_ON: mact = 1'b1;
            PPCI_MSEL_SW: mact = gain_s;
            default:      mact = 1'b0;
        endcase
    end

    assign delta = mact ? cfg_q.factor : 7'h01;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multiplier_active_out_o <= 1'b0;
        end else begin
            multiplier_active_out_o <= mact;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            position_o <= 32'h0000_0000;
            cmd_step_o <= 1'b0;
        end else begin
            cmd_step_o <= step;
            if (wb_wr && wb_adr_i == `PPC_OFF_POS) begin
                position_o <= merge(position_o);
            end else if (step && step_dir) begin
                position_o <= position_o - {25'h0, delta};
            end else if (step) begin
                position_o <= position_o + {25'h0, delta};
            end
        end
    end

    // commanded rate: scaled pulses per measurement window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_q      <= 32'h0000_0000;
            rate_acc_q <= 32'h0000_0000;
            rate_q     <= 32'h0000_0000;
        end else if (win_q == 32'(RATE_WIN_CYC - 1)) begin
            win_q      <= 32'h0000_0000;
            rate_q     <= rate_acc_q + (step ? {25'h0, delta} : 32'h0);
            rate_acc_q <= 32'h0000_0000;
        end else begin
            win_q <= win_q + 32'h0000_0001;
            if (step) begin
                rate_acc_q <= rate_acc_q + {25'h0, delta};
            end
        end
    end

    // ************************************************************
    // wishbone answer
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    `PPC_OFF_CTRL:   wb_dat_o <= ctrl_rd;
                    `PPC_OFF_CWIDTH: wb_dat_o <= {19'h0, cfg_q.cwidth};
                    `PPC_OFF_FACTOR: wb_dat_o <= {25'h0, cfg_q.factor};
                    `PPC_OFF_STATUS: wb_dat_o <= {30'h0, gain_s, mact};
                    `PPC_OFF_POS:    wb_dat_o <= position_o;
                    `PPC_OFF_RATE:   wb_dat_o <= rate_q;
                    default:         wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    mult_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q.msel == PPCI_MSEL_OFF |=> !multiplier_active_out_o)
        else $error("status on while multiplier disabled");

    mult_on_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q.msel == PPCI_MSEL_ON |=> multiplier_active_out_o)
        else $error("status off while multiplier forced");

    mult_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q.msel == PPCI_MSEL_SW |=> multiplier_active_out_o == $past(gain_s))
        else $error("status does not follow switch input");

    count_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step && !mact && !step_dir && !wb_wr
        |=> position_o == $past(position_o) + 32'h1)
        else $error("inactive multiplier did not count once");

    count_mult_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step && mact && step_dir && !wb_wr
        |=> position_o == $past(position_o) - {25'h0, $past(cfg_q.factor)})
        else $error("active multiplier count wrong");

    resv_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q.src == PPCI_SRC_RESV && !wb_wr |=> $stable(position_o))
        else $error("reserved source moved the position");

    factor_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q.factor >= `PPC_FACTOR_MIN && cfg_q.factor <= `PPC_FACTOR_MAX)
        else $error("factor out of range");

    custom_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_q.filt == `PPC_FILT_CUSTOM ##1 cfg_q.filt == `PPC_FILT_CUSTOM
        |-> width_q == $past(cfg_q.cwidth))
        else $error("custom width not applied");

    hold_pos_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !step && !wb_wr |=> $stable(position_o))
        else $error("position moved without a pulse");

endmodule // ppci_top
`default_nettype wire
